// ==== verilog/dmsp_top.sv ====
// two asynchronous serial ports acting as the modem side of the link
// How it works
// - port a has data in/out, request/clear to send and four modem lines.
// - on every line low means a zero bit or an asserted control.
// - the device takes data, request and terminal ready in, drives the rest.
// - port a receives on its serial input and sends on its serial output.
// - port a frames are 8 data bits, no parity, one stop bit.
// - port a runs at one fixed selected rate from 115200 to 921600 bps.
// - port a supports request/clear to send hardware flow control.
// - port b has only data in/out and the request/clear to send pair.
// - port b has no ring line nor any other modem line.
// - port b frames are 8 data bits, no parity, one or two stop bits.
// - port b runs at one fixed selected rate from 115200 to 921600 bps.
// - port b supports request/clear to send hardware flow control.
`timescale 1ns/100ps

// one serial engine: transmitter, receiver, flow control
module dmsp_uart (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] rate_sel,
    input wire logic two_stop,
    input wire logic serial_in,
    input wire logic request_to_send_in_n,
    output logic serial_out,
    output logic clear_to_send_out_n,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output dmsp_pkg::dmsp_rx_err_type rx_err
);

    typedef struct packed {
        dmsp_pkg::dmsp_tx_state_type tx_st;
        logic [dmsp_pkg::CNT_W-1:0] tx_cnt;
        logic [2:0] tx_bit;
        logic tx_second;
        logic [7:0] tx_shift;
        logic tx_line;
        logic [1:0] rts_sync;
        logic [1:0] rx_sync;
        dmsp_pkg::dmsp_rx_state_type rx_st;
        logic [dmsp_pkg::CNT_W-1:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_shift;
        logic [7:0] rx_data;
        logic rx_full;
        logic cts_n;
        dmsp_pkg::dmsp_rx_err_type err;
    } dmsp_uart_state_type;
    dmsp_uart_state_type q;
    dmsp_uart_state_type d;
    logic [dmsp_pkg::CNT_W-1:0] last;
    // last count of a bit period; rate is fixed, no auto detection
    function automatic logic [dmsp_pkg::CNT_W-1:0] bit_last(
        input logic [1:0] sel);
        case (sel)
            dmsp_pkg::SEL_115K:
                bit_last = dmsp_pkg::CNT_W'(dmsp_pkg::CYC_115K - 1);
            dmsp_pkg::SEL_230K:
                bit_last = dmsp_pkg::CNT_W'(dmsp_pkg::CYC_230K - 1);
            dmsp_pkg::SEL_460K:
                bit_last = dmsp_pkg::CNT_W'(dmsp_pkg::CYC_460K - 1);
            default:
                bit_last = dmsp_pkg::CNT_W'(dmsp_pkg::CYC_921K - 1);
        endcase
    endfunction
    assign last = bit_last(rate_sel);
    // a new character is taken only while the far end asserts request
    assign tx_ready = (q.tx_st == dmsp_pkg::TX_IDLE) && !q.rts_sync[1];
    assign serial_out = q.tx_line;
    assign clear_to_send_out_n = q.cts_n;
    assign rx_data = q.rx_data;
    assign rx_valid = q.rx_full;
    assign rx_err = q.err;

    // next state of both engines
    always_comb begin
        d = q;
        d.rx_sync = {q.rx_sync[0], serial_in};
        d.rts_sync = {q.rts_sync[0], request_to_send_in_n};
        d.err = '0;

        // transmitter; a character in flight always completes
        case (q.tx_st)
            dmsp_pkg::TX_IDLE: begin
                d.tx_line = dmsp_pkg::LINE_IDLE;
                if (tx_valid && tx_ready) begin
                    d.tx_shift = tx_data;
                    d.tx_cnt = last;
                    d.tx_line = 1'h0; // start bit low
                    d.tx_st = dmsp_pkg::TX_START;
                end
            end
            dmsp_pkg::TX_START: begin
                if (q.tx_cnt == '0) begin
                    d.tx_cnt = last;
                    d.tx_line = q.tx_shift[0]; // lsb first
                    d.tx_bit = 3'h0;
                    d.tx_st = dmsp_pkg::TX_DATA;
                end else begin
                    d.tx_cnt = q.tx_cnt - 1'b1;
                end
            end
            dmsp_pkg::TX_DATA: begin
                if (q.tx_cnt == '0) begin
                    d.tx_cnt = last;
                    if (q.tx_bit == dmsp_pkg::LAST_BIT) begin
                        // no parity bit: straight into the stop bit
                        d.tx_line = dmsp_pkg::LINE_IDLE;
                        d.tx_second = two_stop;
                        d.tx_st = dmsp_pkg::TX_STOP;
                    end else begin
                        d.tx_shift = q.tx_shift >> 1;
                        d.tx_line = q.tx_shift[1];
                        d.tx_bit = q.tx_bit + 3'h1;
                    end
                end else begin
                    d.tx_cnt = q.tx_cnt - 1'b1;
                end
            end
            dmsp_pkg::TX_STOP: begin
                if (q.tx_cnt == '0) begin
                    if (q.tx_second) begin
                        d.tx_second = 1'h0; // second stop bit
                        d.tx_cnt = last;
                    end else begin
                        d.tx_st = dmsp_pkg::TX_IDLE;
                    end
                end else begin
                    d.tx_cnt = q.tx_cnt - 1'b1;
                end
            end
            default: d.tx_st = dmsp_pkg::TX_IDLE;
        endcase

        // user drains the holding register
        if (q.rx_full && rx_ready) begin
            d.rx_full = 1'h0;
        end

        // receiver samples each bit in its middle
        case (q.rx_st)
            dmsp_pkg::RX_IDLE: begin
                if (!q.rx_sync[1]) begin
                    d.rx_cnt = last >> 1;
                    d.rx_st = dmsp_pkg::RX_START;
                end
            end
            dmsp_pkg::RX_START: begin
                if (q.rx_cnt == '0) begin
                    // a glitch shorter than half a bit is not a start
                    if (q.rx_sync[1]) begin
                        d.rx_st = dmsp_pkg::RX_IDLE;
                    end else begin
                        d.rx_cnt = last;
                        d.rx_bit = 3'h0;
                        d.rx_st = dmsp_pkg::RX_DATA;
                    end
                end else begin
                    d.rx_cnt = q.rx_cnt - 1'b1;
                end
            end
            dmsp_pkg::RX_DATA: begin
                if (q.rx_cnt == '0) begin
                    d.rx_shift = {q.rx_sync[1], q.rx_shift[7:1]};
                    d.rx_cnt = last;
                    if (q.rx_bit == dmsp_pkg::LAST_BIT) begin
                        d.rx_st = dmsp_pkg::RX_STOP;
                    end else begin
                        d.rx_bit = q.rx_bit + 3'h1;
                    end
                end else begin
                    d.rx_cnt = q.rx_cnt - 1'b1;
                end
            end
            dmsp_pkg::RX_STOP: begin
                if (q.rx_cnt == '0) begin
                    // only the first stop is checked, so one or two pass
                    d.rx_st = dmsp_pkg::RX_IDLE;
                    if (!q.rx_sync[1]) begin
                        d.err.frame_error = 1'h1;
                    end else if (q.rx_full && !rx_ready) begin
                        d.err.overrun = 1'h1;
                    end else begin
                        d.rx_data = q.rx_shift;
                        d.rx_full = 1'h1; // load wins over the drain
                    end
                end else begin
                    d.rx_cnt = q.rx_cnt - 1'b1;
                end
            end
            default: d.rx_st = dmsp_pkg::RX_IDLE;
        endcase

        // clear to send negated while the holding register is occupied;
        // the shift register still gives one character of slack
        d.cts_n = d.rx_full;
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.tx_st <= dmsp_pkg::TX_IDLE;
            q.rx_st <= dmsp_pkg::RX_IDLE;
            q.tx_line <= dmsp_pkg::LINE_IDLE;
            q.rts_sync <= {2{dmsp_pkg::CTRL_NEGATED}};
            q.rx_sync <= {2{dmsp_pkg::LINE_IDLE}};
            q.cts_n <= 1'h0;
        end else begin
            q <= d;
        end
    end

endmodule // dmsp_uart

// the two ports and the modem lines of port a
module dmsp_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] port_a_rate_sel,
    input wire logic [1:0] port_b_rate_sel,
    input wire logic port_b_two_stop,
    input wire logic port_a_serial_in,
    output logic port_a_serial_out,
    input wire logic port_a_request_to_send_in_n,
    output logic port_a_clear_to_send_out_n,
    input wire logic port_a_terminal_ready_in_n,
    output logic port_a_set_ready_out_n,
    output logic port_a_carrier_detect_out_n,
    output logic port_a_ring_indicate_out_n,
    input wire logic port_b_serial_in,
    output logic port_b_serial_out,
    input wire logic port_b_request_to_send_in_n,
    output logic port_b_clear_to_send_out_n,
    input wire logic [7:0] port_a_tx_data,
    input wire logic port_a_tx_valid,
    output logic port_a_tx_ready,
    output logic [7:0] port_a_rx_data,
    output logic port_a_rx_valid,
    input wire logic port_a_rx_ready,
    output dmsp_pkg::dmsp_rx_err_type port_a_rx_err,
    input wire logic [7:0] port_b_tx_data,
    input wire logic port_b_tx_valid,
    output logic port_b_tx_ready,
    output logic [7:0] port_b_rx_data,
    output logic port_b_rx_valid,
    input wire logic port_b_rx_ready,
    output dmsp_pkg::dmsp_rx_err_type port_b_rx_err,
    input dmsp_pkg::dmsp_modem_type port_a_modem,
    output logic port_a_terminal_ready
);

    typedef struct packed {
        logic [1:0] dtr_sync;
        dmsp_pkg::dmsp_modem_type modem_n;
    } dmsp_top_state_type;
    dmsp_top_state_type q;
    dmsp_top_state_type d;
    logic [1:0] rst_sync_q;
    logic rst_n;

    // reset release synchroniser; kept apart since it runs on resetn
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'h1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // modem lines of port a, asserted low on the pins
    always_comb begin
        d = q;
        d.dtr_sync = {q.dtr_sync[0], port_a_terminal_ready_in_n};
        d.modem_n = ~port_a_modem;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q.dtr_sync <= {2{dmsp_pkg::CTRL_NEGATED}};
            q.modem_n <= {3{dmsp_pkg::CTRL_NEGATED}};
        end else begin
            q <= d;
        end
    end

    assign port_a_terminal_ready = !q.dtr_sync[1];
    assign port_a_set_ready_out_n = q.modem_n.set_ready;
    assign port_a_carrier_detect_out_n = q.modem_n.carrier_detect;
    assign port_a_ring_indicate_out_n = q.modem_n.ring_indicate;

    // port a: one stop bit only
    dmsp_uart u_port_a (
        .clk(clk),
        .rst_n(rst_n),
        .rate_sel(port_a_rate_sel),
        .two_stop(1'h0),
        .serial_in(port_a_serial_in),
        .request_to_send_in_n(port_a_request_to_send_in_n),
        .serial_out(port_a_serial_out),
        .clear_to_send_out_n(port_a_clear_to_send_out_n),
        .tx_data(port_a_tx_data),
        .tx_valid(port_a_tx_valid),
        .tx_ready(port_a_tx_ready),
        .rx_data(port_a_rx_data),
        .rx_valid(port_a_rx_valid),
        .rx_ready(port_a_rx_ready),
        .rx_err(port_a_rx_err)
    );

    // port b: four wires, no modem lines at all
    dmsp_uart u_port_b (
        .clk(clk),
        .rst_n(rst_n),
        .rate_sel(port_b_rate_sel),
        .two_stop(port_b_two_stop),
        .serial_in(port_b_serial_in),
        .request_to_send_in_n(port_b_request_to_send_in_n),
        .serial_out(port_b_serial_out),
        .clear_to_send_out_n(port_b_clear_to_send_out_n),
        .tx_data(port_b_tx_data),
        .tx_valid(port_b_tx_valid),
        .tx_ready(port_b_tx_ready),
        .rx_data(port_b_rx_data),
        .rx_valid(port_b_rx_valid),
        .rx_ready(port_b_rx_ready),
        .rx_err(port_b_rx_err)
    );

endmodule // dmsp_top

// ==== verilog/dmsp_pkg.sv ====
// shared constants and types for the dual modem serial ports
package dmsp_pkg;

    // system clock and the documented bit rate range
    localparam int CLK_HZ = 125000000;
    localparam int RATE_115K = 115200;
    localparam int RATE_230K = 230400;
    localparam int RATE_460K = 460800;
    localparam int RATE_921K = 921600;

    // clocks per bit, rounded to nearest; 921600 gives 136 (+0.3 %)
    localparam int CYC_115K = (CLK_HZ + RATE_115K / 2) / RATE_115K;
    localparam int CYC_230K = (CLK_HZ + RATE_230K / 2) / RATE_230K;
    localparam int CYC_460K = (CLK_HZ + RATE_460K / 2) / RATE_460K;
    localparam int CYC_921K = (CLK_HZ + RATE_921K / 2) / RATE_921K;

    // rate select encodings
    localparam logic [1:0] SEL_115K = 2'h0;
    localparam logic [1:0] SEL_230K = 2'h1;
    localparam logic [1:0] SEL_460K = 2'h2;
    localparam logic [1:0] SEL_921K = 2'h3;

    // frame layout
    localparam int DATA_BITS = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int CNT_W = 11;

    // reset values of line levels: idle high, controls negated high
    localparam logic LINE_IDLE = 1'h1;
    localparam logic CTRL_NEGATED = 1'h1;

    typedef enum logic [3:0] {
        TX_IDLE  = 4'h1,
        TX_START = 4'h2,
        TX_DATA  = 4'h4,
        TX_STOP  = 4'h8
    } dmsp_tx_state_type;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_DATA  = 4'h4,
        RX_STOP  = 4'h8
    } dmsp_rx_state_type;

    // modem status that the device side wants to show, active high
    typedef struct packed {
        logic set_ready;
        logic carrier_detect;
        logic ring_indicate;
    } dmsp_modem_type;

    // receive error pulses
    typedef struct packed {
        logic frame_error;
        logic overrun;
    } dmsp_rx_err_type;

endpackage

// ==== dv/dmsp_assertions.sv ====
// concurrent checks on the serial port top pins and user handshakes
`timescale 1ns/100ps
module dmsp_assertions (
    input wire logic clk,
    input wire logic resetn,
    input wire logic port_a_tx_valid,
    input wire logic port_a_tx_ready,
    input wire logic port_a_serial_out,
    input wire logic port_b_tx_valid,
    input wire logic port_b_tx_ready,
    input wire logic port_b_serial_out,
    input wire logic port_a_request_to_send_in_n,
    input wire logic port_a_clear_to_send_out_n,
    input wire logic port_b_clear_to_send_out_n,
    input wire logic port_a_rx_valid,
    input wire logic port_b_rx_valid,
    input wire logic port_a_rx_ready,
    input wire logic [7:0] port_a_rx_data
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!resetn);
    // a take, then a start bit that holds low while the sender is busy
    sequence take_a_s; port_a_tx_valid && port_a_tx_ready; endsequence
    sequence take_b_s; port_b_tx_valid && port_b_tx_ready; endsequence
    sequence low_a_s;
        (!port_a_serial_out && !port_a_tx_ready) [*8];
    endsequence
    sequence low_b_s;
        (!port_b_serial_out && !port_b_tx_ready) [*8];
    endsequence
    start_a_a: assert property (take_a_s |=> low_a_s)
        else $error("port a start bit missing");
    start_b_a: assert property (take_b_s |=> low_b_s)
        else $error("port b start bit missing");
    // a free sender must leave its line at the idle level
    idle_a_a: assert property (port_a_tx_ready |-> port_a_serial_out)
        else $error("port a line not idle");
    idle_b_a: assert property (port_b_tx_ready |-> port_b_serial_out)
        else $error("port b line not idle");
    // three synced samples of a negated request must block a take
    rts_hold_a: assert property (port_a_request_to_send_in_n [*3]
        |-> !port_a_tx_ready) else $error("sender ignores request");
    // clear to send is negated exactly while a character is held
    cts_a_a: assert property (port_a_clear_to_send_out_n == port_a_rx_valid)
        else $error("port a clear to send wrong");
    cts_b_a: assert property (port_b_clear_to_send_out_n == port_b_rx_valid)
        else $error("port b clear to send wrong");
    rx_hold_a: assert property (port_a_rx_valid && !port_a_rx_ready
        |=> port_a_rx_valid && $stable(port_a_rx_data))
        else $error("held character lost");
endmodule // dmsp_assertions

// ==== dv/dmsp_dte_model.sv ====
// terminal-side partner: serial frames in and out, request line
`timescale 1ns/100ps
module dmsp_dte_model (
    input wire logic clk,
    input wire logic from_dce, // modem data toward the terminal
    input wire logic cts_n,
    output logic to_dce, // terminal data into the modem
    output logic rts_n
);
    int bit_cyc = 136;
    int stop_bad = 0;
    int cts_to = 0;
    logic [7:0] got_byte = 8'h00;
    // idle line high, request asserted low so the modem may send
    initial begin
        to_dce = 1'b1;
        rts_n = 1'b0;
    end
    // one frame out; it waits for clear unless told to overrun on purpose
    task automatic send(input logic [7:0] b, input logic stop_v,
        input logic obey);
        int i;
        for (i = 0; i < 50000 && obey && cts_n !== 1'b0; i++)
            @(negedge clk);
        if (i == 50000)
            cts_to++;
        to_dce = 1'b0;
        repeat (bit_cyc) @(negedge clk);
        for (i = 0; i < 8; i++) begin
            to_dce = b[i];
            repeat (bit_cyc) @(negedge clk);
        end
        to_dce = stop_v;
        repeat (bit_cyc) @(negedge clk);
        to_dce = 1'b1;
    endtask
    // mid-bit sampling away from edges; a second stop bit passes unseen
    always begin
        @(negedge from_dce);
        repeat (bit_cyc / 2) @(negedge clk);
        for (int k = 0; k < 8; k++) begin
            repeat (bit_cyc) @(negedge clk);
            got_byte[k] = from_dce;
        end
        repeat (bit_cyc) @(negedge clk);
        stop_bad += int'(from_dce !== 1'b1);
    end
endmodule // dmsp_dte_model

// ==== dv/dmsp_top_bench.sv ====
// self-checking bench for the dual modem serial ports
`timescale 1ns/100ps
module dmsp_top_bench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] sel [2] = '{2'h3, 2'h3};
    logic two_stop = 1'b0;
    logic dtr_n = 1'b1;
    dmsp_pkg::dmsp_modem_type modem = 3'h0;
    logic [7:0] txd [2] = '{8'h00, 8'h00};
    logic [1:0] txv = 2'h0;
    logic [1:0] rxr = 2'h0;
    wire [1:0] txr, rxv, sin, sout, rts, cts;
    wire [7:0] rxd [2];
    wire [2:0] mo_n;
    wire dtr;
    wire dmsp_pkg::dmsp_rx_err_type ea, eb;
    int err_total = 0;
    int num_checks = 0;
    int ovr [2] = '{0, 0};
    int fer [2] = '{0, 0};
    int nb [4] = '{dmsp_pkg::CYC_115K, dmsp_pkg::CYC_230K,
        dmsp_pkg::CYC_460K, dmsp_pkg::CYC_921K};
    // 125 MHz clock
    always #4 clk = ~clk;
    // error pulses stand one cycle only, so tally them as they pass;
    // looked at on the falling edge, away from the edge that launches them
    always @(negedge clk) begin
        ovr[0] += int'(ea.overrun === 1'b1);
        ovr[1] += int'(eb.overrun === 1'b1);
        fer[0] += int'(ea.frame_error === 1'b1);
        fer[1] += int'(eb.frame_error === 1'b1);
    end
    dmsp_top dmsp_top_i (.clk(clk), .resetn(resetn),
        .port_a_rate_sel(sel[0]), .port_b_rate_sel(sel[1]),
        .port_b_two_stop(two_stop), .port_a_terminal_ready_in_n(dtr_n),
        .port_a_serial_in(sin[0]), .port_a_serial_out(sout[0]),
        .port_a_request_to_send_in_n(rts[0]),
        .port_a_clear_to_send_out_n(cts[0]),
        .port_a_set_ready_out_n(mo_n[2]),
        .port_a_carrier_detect_out_n(mo_n[1]),
        .port_a_ring_indicate_out_n(mo_n[0]),
        .port_b_serial_in(sin[1]), .port_b_serial_out(sout[1]),
        .port_b_request_to_send_in_n(rts[1]),
        .port_b_clear_to_send_out_n(cts[1]),
        .port_a_tx_data(txd[0]), .port_a_tx_valid(txv[0]),
        .port_a_tx_ready(txr[0]), .port_a_rx_data(rxd[0]),
        .port_a_rx_valid(rxv[0]), .port_a_rx_ready(rxr[0]),
        .port_a_rx_err(ea), .port_b_tx_data(txd[1]),
        .port_b_tx_valid(txv[1]), .port_b_tx_ready(txr[1]),
        .port_b_rx_data(rxd[1]), .port_b_rx_valid(rxv[1]),
        .port_b_rx_ready(rxr[1]), .port_b_rx_err(eb),
        .port_a_modem(modem), .port_a_terminal_ready(dtr));
    dmsp_dte_model dte_a_i (.clk(clk), .from_dce(sout[0]), .cts_n(cts[0]),
        .to_dce(sin[0]), .rts_n(rts[0]));
    dmsp_dte_model dte_b_i (.clk(clk), .from_dce(sout[1]), .cts_n(cts[1]),
        .to_dce(sin[1]), .rts_n(rts[1]));
    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp_int(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("wrong value at %0t: count %0d", $time, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic hang();
        err_total++;
        $display("wrong value at %0t: wait ran out", $time);
        end_of_test();
    endtask
    // hold valid until a ready edge takes it; count cycles until free again
    task automatic tx(input int p, input logic [7:0] b, output int n);
        int i;
        txd[p] = b;
        txv[p] = 1'b1;
        for (i = 0; i < 400 && txr[p] !== 1'b1; i++) @(negedge clk);
        if (i == 400) hang();
        @(negedge clk);
        txv[p] = 1'b0;
        for (n = 1; n < 20000 && txr[p] !== 1'b1; n++) @(negedge clk);
        if (n == 20000) hang();
    endtask
    task automatic rx_send(input int p, input logic [7:0] b,
        input logic stop_v, input logic obey);
        if (p == 1) dte_b_i.send(b, stop_v, obey);
        else dte_a_i.send(b, stop_v, obey);
        repeat (4) @(negedge clk);
    endtask
    // modem status outputs mirror the user levels inverted
    task automatic t_modem();
        for (int m = 0; m < 8; m++) begin
            modem = m[2:0];
            dtr_n = m[0];
            repeat (4) @(negedge clk);
            cmp_val({5'h00, mo_n}, {5'h00, ~m[2:0]});
            cmp_val({7'h00, dtr}, {7'h00, ~m[0]});
        end
    endtask
    // one character per rate: pattern and frame length both judged
    task automatic t_rates();
        int n, e;
        for (int s = 0; s < 4; s++) begin
            sel[0] = s[1:0];
            dte_a_i.bit_cyc = nb[s];
            e = 10 * nb[s];
            tx(0, 8'h5a ^ s[7:0], n);
            cmp_val(dte_a_i.got_byte, 8'h5a ^ s[7:0]);
            cmp_int(n, e - 1, e + 2);
        end
        sel[0] = 2'h3;
        dte_a_i.bit_cyc = nb[3];
    endtask
    // port b back to back, one then two stop bits at two rates
    task automatic t_stops();
        int n, e;
        for (int t = 0; t < 2; t++) begin
            two_stop = t[0];
            sel[1] = 2'h3 - t[1:0];
            dte_b_i.bit_cyc = nb[3 - t];
            e = (10 + t) * nb[3 - t];
            tx(1, 8'h81 ^ t[7:0], n);
            cmp_int(n, e - 1, e + 2);
            cmp_val(dte_b_i.got_byte, 8'h81 ^ t[7:0]);
        end
        two_stop = 1'b0;
        sel[1] = 2'h3;
        dte_b_i.bit_cyc = nb[3];
    endtask
    // a negated request holds the character back until it returns
    task automatic t_flow();
        int n;
        dte_a_i.rts_n = 1'b1;
        repeat (4) @(negedge clk);
        txd[0] = 8'hc3;
        txv[0] = 1'b1;
        repeat (3 * nb[3]) @(negedge clk);
        cmp_val({6'h00, txr[0], sout[0]}, 8'h01);
        dte_a_i.rts_n = 1'b0;
        tx(0, 8'hc3, n);
        cmp_val(dte_a_i.got_byte, 8'hc3);
    endtask
    // receive, hold while full, overrun, drain, then a broken stop bit
    task automatic t_rx(input int p);
        rx_send(p, 8'h3c, 1'b1, 1'b1);
        cmp_val(rxd[p], 8'h3c);
        cmp_val({6'h00, rxv[p], cts[p]}, 8'h03);
        rx_send(p, 8'he1, 1'b1, 1'b0);
        cmp_int(ovr[p], 1, 1);
        cmp_val(rxd[p], 8'h3c);
        rxr[p] = 1'b1;
        @(negedge clk);
        rxr[p] = 1'b0;
        @(negedge clk);
        cmp_val({6'h00, rxv[p], cts[p]}, 8'h00);
        rx_send(p, 8'h96, 1'b0, 1'b1);
        cmp_int(fer[p], 1, 1);
        cmp_val({7'h00, rxv[p]}, 8'h00);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
        cmp_val({4'h0, sout, cts}, 8'h0c);
        t_modem();
        t_rates();
        t_stops();
        t_flow();
        t_rx(0);
        t_rx(1);
        cmp_int(dte_a_i.stop_bad + dte_b_i.stop_bad, 0, 0);
        cmp_int(dte_a_i.cts_to + dte_b_i.cts_to, 0, 0);
        end_of_test();
    end
endmodule // dmsp_top_bench
bind dmsp_top dmsp_assertions dmsp_assertions_i (.*);
